/* File: src/srm_pkg.sv */
// Package holding the constants and state type of the reference margin and latency block.
package srm_pkg;

    // Register byte addresses on the 12-bit APB address.
    localparam logic [11:0] SRM_STATUS_OFF = 12'h128;
    localparam logic [11:0] SRM_MON_OFF = 12'h12c;
    localparam logic [11:0] SRM_LAT_CTRL_OFF = 12'h130;
    localparam logic [11:0] SRM_LAT_TOTAL_OFF = 12'h134;
    localparam logic [11:0] SRM_LAT_PART_OFF = 12'h138;

    // Field positions.
    localparam int SRM_SETUP_LSB = 0;
    localparam int SRM_HOLD_LSB = 4;
    localparam int SRM_MON_CAPT_BIT = 0;
    localparam int SRM_MON_CLS_LSB = 1;
    localparam int SRM_CTRL_DEC_LSB = 0;
    localparam int SRM_CTRL_CPLX_BIT = 6;
    localparam int SRM_CTRL_CONV_LSB = 8;
    localparam int SRM_CTRL_LANES_LSB = 12;
    localparam int SRM_TOT_SUP_BIT = 31;
    localparam int SRM_PART_LINK_LSB = 16;

    // Values after reset.
    localparam logic [5:0] SRM_DEC_RST = 6'h00;
    localparam logic [3:0] SRM_CONV_RST = 4'h1;
    localparam logic [3:0] SRM_LANES_RST = 4'h1;

    // Detector width and code thresholds.
    localparam int SRM_TAPS = 15;
    localparam logic [3:0] SRM_CODE_MID = 4'h8;
    localparam logic [3:0] SRM_CODE_ZERO = 4'h0;

    // Margin classes.
    localparam logic [1:0] SRM_CLS_OK = 2'h0;
    localparam logic [1:0] SRM_CLS_SETUP = 2'h1;
    localparam logic [1:0] SRM_CLS_HOLD = 2'h2;
    localparam logic [1:0] SRM_CLS_EITHER = 2'h3;

    // Index of the converters-per-lane ratio 1 in the 0.125 to 8 span.
    localparam logic [3:0] SRM_RATIO_ONE = 4'h3;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] setup_code;
        logic [3:0] hold_code;
        logic [1:0] cls;
        logic captured;
        logic [5:0] dec;
        logic cplx;
        logic [3:0] conv;
        logic [3:0] lanes;
        logic [11:0] dsp_lat;
        logic [11:0] link_lat;
        logic [11:0] total;
        logic supported;
    } srm_state_t;

endpackage

/* File: src/srm_monitor.sv */
// Reference setup/hold margin monitor and deterministic latency calculator with an APB slave.
//
// What this block does
// - Setup detector samples before the clock edge; code in status bits 3:0.
// - Hold detector samples after the clock edge; code in status bits 7:4.
// - Status at 0x128 holds setup/hold codes; whether reference was captured is bit 0 at 0x12c.
// - Hold zero, setup 1 to 7: possible setup error, smaller code less margin.
// - Setup eight, hold 0 to 8: no error, best hold margin.
// - Hold eight, setup 9 to 15: no error, best setup and hold margin.
// - Hold eight, setup zero: no error, best setup margin.
// - Hold 9 to 15, setup zero: possible hold error, larger code less margin.
// - Both codes zero: possible setup or hold error.
// - Latency is fixed for any fixed mode and link configuration.
// - Total latency is converter-plus-DSP delay plus link block delay.
// - All latency figures count sample clocks and are typical.
// - Link block delay does not depend on real or complex output.
// - Converter-plus-DSP delay: 31 full bandwidth, 90 first half-band, 102 third-band.
// - Full bandwidth link delay: 82, 44, 14 at ratios 1/8, 1/4, 1.
// - Mode and ratio pairs marked not applicable are unsupported.
// - Ratio is number of converters divided by number of lanes.
// - Decimate-by-five is only available with real output.
// - Decimation 15, 16, 30, 40, 48 only with complex output.
// - Decimation mode number equals the applied decimation ratio, except mode 0, which is full bandwidth.
module srm_monitor
    import srm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Reference detectors.
    input wire logic sref_capture,
    input wire logic [14:0] sref_setup_taps,
    input wire logic [14:0] sref_hold_taps,
    // Status outputs.
    output logic [7:0] sref_status,
    output logic sref_captured,
    output logic [1:0] sref_margin_class,
    output logic [11:0] latency_total,
    output logic [11:0] latency_dsp,
    output logic [11:0] latency_link,
    output logic latency_supported
);

    srm_state_t st_ff;
    srm_state_t nxt_st;

    // Count of taps that saw the reference high.
    function automatic logic [3:0] tap_count(input logic [14:0] taps);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < SRM_TAPS; i++) begin
            n = n + {3'h0, taps[i]};
        end
        return n;
    endfunction

    function automatic logic [1:0] classify(input logic [3:0] h, input logic [3:0] s);
        logic [1:0] c;
        if (h == SRM_CODE_ZERO && s == SRM_CODE_ZERO) begin
            c = SRM_CLS_EITHER;
        end else if (h == SRM_CODE_ZERO && s < SRM_CODE_MID) begin
            c = SRM_CLS_SETUP;
        end else if (s == SRM_CODE_MID && h <= SRM_CODE_MID) begin
            c = SRM_CLS_OK;
        end else if (h == SRM_CODE_MID && s > SRM_CODE_MID) begin
            c = SRM_CLS_OK;
        end else if (h == SRM_CODE_MID && s == SRM_CODE_ZERO) begin
            c = SRM_CLS_OK;
        end else if (s == SRM_CODE_ZERO && h > SRM_CODE_MID) begin
            c = SRM_CLS_HOLD;
        end else begin
            // Codes off the documented diagonal are flagged as doubtful on both sides.
            c = SRM_CLS_EITHER;
        end
        return c;
    endfunction

    // Log2 of a converter or lane count; only 1, 2, 4 and 8 are legal.
    function automatic logic [2:0] log2_cnt(input logic [3:0] v);
        logic [2:0] r;
        unique case (v)
            4'h1: r = 3'h0;
            4'h2: r = 3'h1;
            4'h4: r = 3'h2;
            4'h8: r = 3'h3;
            default: r = 3'h4;
        endcase
        return r;
    endfunction

    // Converter-plus-DSP delay in sample clocks by decimation ratio and data type; zero is absent.
    function automatic logic [11:0] dsp_delay(input logic [5:0] d, input logic cx);
        logic [11:0] r;
        r = 12'h000;
        if (d == 6'h00) begin
            r = 12'h01f;
        end else if (!cx) begin
            unique case (d)
                6'h01: r = 12'h05a;
                6'h02: r = 12'h0a2;
                6'h03: r = 12'h0d4;
                6'h04: r = 12'h124;
                6'h05: r = 12'h17c;
                6'h06: r = 12'h1a8;
                6'h08: r = 12'h228;
                6'h0a: r = 12'h2b6;
                6'h0c: r = 12'h32e;
                6'h14: r = 12'h58c;
                6'h18: r = 12'h63a;
                default: r = 12'h000;
            endcase
        end else begin
            unique case (d)
                6'h02: r = 12'h05a;
                6'h03: r = 12'h066;
                6'h04: r = 12'h0a2;
                6'h06: r = 12'h0d4;
                6'h08: r = 12'h124;
                6'h0a: r = 12'h17c;
                6'h0c: r = 12'h1a8;
                6'h0f: r = 12'h1f4;
                6'h10: r = 12'h228;
                6'h14: r = 12'h2b6;
                6'h18: r = 12'h32e;
                6'h1e: r = 12'h344;
                6'h28: r = 12'h58c;
                6'h30: r = 12'h63a;
                default: r = 12'h000;
            endcase
        end
        return r;
    endfunction

    // Link block delay row, ratio 8 in the top entry down to 1/8 in the bottom; zero is N/A.
    // The data type is not an argument, since the link delay ignores it.
    function automatic logic [83:0] link_row(input logic [5:0] d);
        logic [83:0] r;
        unique case (d)
            6'h00: r = {12'h003, 12'h009, 12'h007, 12'h00e, 12'h019, 12'h02c, 12'h052};
            6'h01: r = {12'h000, 12'h000, 12'h007, 12'h00e, 12'h019, 12'h02c, 12'h052};
            6'h02: r = {12'h000, 12'h007, 12'h00e, 12'h01b, 12'h02e, 12'h054, 12'h0a0};
            6'h03: r = {12'h000, 12'h00b, 12'h015, 12'h027, 12'h043, 12'h07c, 12'h0ed};
            6'h04: r = {12'h009, 12'h00e, 12'h01b, 12'h032, 12'h058, 12'h0a4, 12'h13b};
            6'h05: r = {12'h000, 12'h000, 12'h02b, 12'h03e, 12'h06d, 12'h0cb, 12'h000};
            6'h06: r = {12'h00e, 12'h015, 12'h027, 12'h049, 12'h082, 12'h0f3, 12'h000};
            6'h08: r = {12'h012, 12'h01b, 12'h032, 12'h060, 12'h0ac, 12'h143, 12'h000};
            6'h0a: r = {12'h016, 12'h021, 12'h03e, 12'h077, 12'h0d5, 12'h000, 12'h000};
            6'h0c: r = {12'h01b, 12'h027, 12'h049, 12'h08e, 12'h0ff, 12'h000, 12'h000};
            6'h0f: r = {12'h021, 12'h02f, 12'h05a, 12'h0b0, 12'h13e, 12'h000, 12'h000};
            6'h10: r = {12'h023, 12'h032, 12'h060, 12'h0bc, 12'h153, 12'h000, 12'h000};
            6'h14: r = {12'h02b, 12'h03e, 12'h077, 12'h0e9, 12'h000, 12'h000, 12'h000};
            6'h18: r = {12'h033, 12'h049, 12'h08e, 12'h117, 12'h000, 12'h000, 12'h000};
            6'h1e: r = {12'h03e, 12'h05a, 12'h0b0, 12'h15c, 12'h000, 12'h000, 12'h000};
            6'h28: r = {12'h052, 12'h077, 12'h0e9, 12'h000, 12'h000, 12'h000, 12'h000};
            6'h30: r = {12'h061, 12'h08e, 12'h117, 12'h000, 12'h000, 12'h000, 12'h000};
            default: r = 84'h0;
        endcase
        return r;
    endfunction

    // Combinational helpers for the latency path and the APB read path.
    logic [2:0] lg_conv;
    logic [2:0] lg_lanes;
    logic ratio_ok;
    logic [3:0] ratio_idx;
    logic [11:0] dsp_val;
    logic [11:0] link_val;
    logic [83:0] row_val;
    logic type_ok;
    logic [31:0] rd_val;
    logic rd_hit;
    logic acc_done;

    always_comb begin
        lg_conv = log2_cnt(st_ff.conv);
        lg_lanes = log2_cnt(st_ff.lanes);
        ratio_ok = !lg_conv[2] && !lg_lanes[2];
        // Index 0 is ratio 1/8 and 6 is ratio 8: converters over lanes.
        ratio_idx = {2'h0, lg_conv[1:0]} + SRM_RATIO_ONE - {2'h0, lg_lanes[1:0]};
        dsp_val = dsp_delay(st_ff.dec, st_ff.cplx);
        // The row is held in a variable first, since a function result cannot be sliced.
        row_val = link_row(st_ff.dec);
        link_val = ratio_ok ? row_val[ratio_idx * 12 +: 12] : 12'h000;
        // Data type limits on the decimation modes.
        type_ok = !((st_ff.dec == 6'h05) && st_ff.cplx)
            && !((st_ff.dec == 6'h0f || st_ff.dec == 6'h10 || st_ff.dec == 6'h1e
                  || st_ff.dec == 6'h28 || st_ff.dec == 6'h30) && !st_ff.cplx);
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        unique case (paddr)
            SRM_STATUS_OFF: rd_val[7:0] = {st_ff.hold_code, st_ff.setup_code};
            SRM_MON_OFF: rd_val[2:0] = {st_ff.cls, st_ff.captured};
            SRM_LAT_CTRL_OFF: rd_val[15:0] = {st_ff.lanes, st_ff.conv, 1'b0, st_ff.cplx,
                                              st_ff.dec};
            SRM_LAT_TOTAL_OFF: rd_val = {st_ff.supported, 19'h0, st_ff.total};
            SRM_LAT_PART_OFF: rd_val = {4'h0, st_ff.link_lat, 4'h0, st_ff.dsp_lat};
            default: begin
                rd_hit = 1'b0;
                rd_val = 32'h0;
            end
        endcase
    end

    assign acc_done = psel && penable && st_ff.pready;

    always_comb begin
        nxt_st = st_ff;
        // One wait state: pready rises in the second access cycle.
        nxt_st.pready = psel && penable && !st_ff.pready;
        nxt_st.prdata = (psel && penable && !st_ff.pready && !pwrite) ? rd_val : 32'h0;
        nxt_st.pslverr = psel && penable && !st_ff.pready && !rd_hit;
        // Writes to the status word are accepted and ignored.
        if (acc_done && pwrite && paddr == SRM_LAT_CTRL_OFF) begin
            if (pstrb[0]) begin
                nxt_st.dec = pwdata[SRM_CTRL_DEC_LSB +: 6];
                nxt_st.cplx = pwdata[SRM_CTRL_CPLX_BIT];
            end
            if (pstrb[1]) begin
                nxt_st.conv = pwdata[SRM_CTRL_CONV_LSB +: 4];
                nxt_st.lanes = pwdata[SRM_CTRL_LANES_LSB +: 4];
            end
        end
        if (acc_done && pwrite && paddr == SRM_MON_OFF && pstrb[0]
            && pwdata[SRM_MON_CAPT_BIT]) begin
            nxt_st.captured = 1'b0;
        end
        // A capture in the clearing cycle wins over the clear.
        if (sref_capture) begin
            nxt_st.setup_code = tap_count(sref_setup_taps);
            nxt_st.hold_code = tap_count(sref_hold_taps);
            nxt_st.cls = classify(tap_count(sref_hold_taps), tap_count(sref_setup_taps));
            nxt_st.captured = 1'b1;
        end
        // Latency follows the settings alone, so it is the same every time.
        nxt_st.supported = ratio_ok && type_ok && dsp_val != 12'h000
            && link_val != 12'h000;
        nxt_st.dsp_lat = nxt_st.supported ? dsp_val : 12'h000;
        nxt_st.link_lat = nxt_st.supported ? link_val : 12'h000;
        nxt_st.total = nxt_st.supported ? dsp_val + link_val : 12'h000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0, setup_code: 4'h0,
                       hold_code: 4'h0, cls: SRM_CLS_EITHER, captured: 1'b0,
                       dec: SRM_DEC_RST, cplx: 1'b0, conv: SRM_CONV_RST,
                       lanes: SRM_LANES_RST, dsp_lat: 12'h0, link_lat: 12'h0,
                       total: 12'h0, supported: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pready = st_ff.pready;
    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.pslverr;
    assign sref_status = {st_ff.hold_code, st_ff.setup_code};
    assign sref_captured = st_ff.captured;
    assign sref_margin_class = st_ff.cls;
    assign latency_total = st_ff.total;
    assign latency_dsp = st_ff.dsp_lat;
    assign latency_link = st_ff.link_lat;
    assign latency_supported = st_ff.supported;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_setup_capture: assert property (sref_capture |=>
        sref_status[3:0] == tap_count($past(sref_setup_taps)))
        else $error("setup code not taken from the setup taps");
    a_hold_capture: assert property (sref_capture |=>
        sref_status[7:4] == tap_count($past(sref_hold_taps)))
        else $error("hold code not taken from the hold taps");
    a_status_frozen: assert property (!sref_capture |=> $stable(sref_status))
        else $error("status changed without a capture");
    a_captured_flag: assert property (sref_capture |=> sref_captured [*1])
        else $error("capture flag not set after a capture");
    a_setup_class: assert property (sref_status[7:4] == 4'h0 && sref_status[3:0] != 4'h0
        && sref_status[3:0] < 4'h8 && $past(sref_capture) |-> sref_margin_class == SRM_CLS_SETUP)
        else $error("setup error class missing");
    a_hold_class: assert property ($past(sref_capture) && sref_status[3:0] == 4'h0
        && sref_status[7:4] > 4'h8 |-> sref_margin_class == SRM_CLS_HOLD)
        else $error("hold error class missing");
    a_ok_class: assert property ($past(sref_capture) && sref_status[3:0] == 4'h8
        && sref_status[7:4] <= 4'h8 |-> sref_margin_class == SRM_CLS_OK)
        else $error("best hold margin not reported as clean");
    a_total_sum: assert property (latency_supported
        |-> latency_total == latency_dsp + latency_link)
        else $error("total latency is not the sum of its parts");
    a_latency_fixed: assert property ($past(presetn) && $stable(st_ff.dec)
        && $stable(st_ff.conv) && $stable(st_ff.lanes) && $stable(st_ff.cplx)
        |=> $stable(latency_total))
        else $error("latency moved with fixed settings");
    a_fullbw_ratio1: assert property (st_ff.dec == 6'h00 && st_ff.conv == st_ff.lanes
        && ratio_ok |=> latency_total == 12'h02d)
        else $error("full bandwidth ratio one latency wrong");
    a_dcm5_real: assert property (st_ff.dec == 6'h05 && st_ff.cplx
        |=> !latency_supported)
        else $error("decimate by five accepted with complex data");
    a_complex_only: assert property (st_ff.dec == 6'h30 && !st_ff.cplx
        |=> !latency_supported)
        else $error("decimate by 48 accepted with real data");

    c_capture: cover property (sref_capture ##1 sref_margin_class == SRM_CLS_OK);
    c_hold_err: cover property (sref_capture ##1 sref_margin_class == SRM_CLS_HOLD);
    c_read: cover property (acc_done && !pwrite && paddr == SRM_STATUS_OFF);
    c_supported: cover property (st_ff.dec == 6'h04 && st_ff.cplx ##1 latency_supported);

endmodule

/* File: testbench/srm_sref_src.sv */
// Model of the reference source that feeds the setup and hold detectors.
module srm_sref_src (
    // Clock.
    input wire logic pclk,
    // Requests from the bench.
    input wire logic fire,
    input wire logic [3:0] setup_code,
    input wire logic [3:0] hold_code,
    // Detector samples towards the monitor.
    output logic sref_capture,
    output logic [14:0] sref_setup_taps,
    output logic [14:0] sref_hold_taps
);
    timeunit 1ns;
    timeprecision 1ps;

    function automatic logic [14:0] therm(input logic [3:0] code);
        therm = 15'h0000;
        for (int i = 0; i < 15; i++) begin
            if (i < code) begin
                therm[i] = 1'b1;
            end
        end
    endfunction

    initial begin
        sref_capture = 1'b0;
        sref_setup_taps = 15'h5555;
        sref_hold_taps = 15'h2aaa;
    end

    // Outside a capture the taps toggle every cycle, so a stale sample never looks valid.
    always @(posedge pclk) begin
        sref_capture <= fire;
        if (fire) begin
            sref_setup_taps <= therm(setup_code);
            sref_hold_taps <= therm(hold_code);
        end else begin
            sref_setup_taps <= ~sref_setup_taps;
            sref_hold_taps <= ~sref_hold_taps;
        end
    end
endmodule

/* File: testbench/test_srm_monitor.sv */
// Self-checking testbench of the reference margin monitor and latency calculator.
module test_srm_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    import srm_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fire;
    logic sref_capture, sref_captured, latency_supported;
    logic [11:0] paddr, latency_total, latency_dsp, latency_link;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, setup_code, hold_code;
    logic [14:0] sref_setup_taps, sref_hold_taps;
    logic [7:0] sref_status;
    logic [1:0] sref_margin_class;
    logic er;
    int n_errors = 0;
    int total_checks = 0;

    srm_monitor srm_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sref_capture(sref_capture),
        .sref_setup_taps(sref_setup_taps), .sref_hold_taps(sref_hold_taps),
        .sref_status(sref_status), .sref_captured(sref_captured),
        .sref_margin_class(sref_margin_class), .latency_total(latency_total),
        .latency_dsp(latency_dsp), .latency_link(latency_link),
        .latency_supported(latency_supported));

    srm_sref_src srm_sref_src_i (.pclk(pclk), .fire(fire), .setup_code(setup_code),
        .hold_code(hold_code), .sref_capture(sref_capture),
        .sref_setup_taps(sref_setup_taps), .sref_hold_taps(sref_hold_taps));

    always #10 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(pready, 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cap_case(input logic [3:0] h, input logic [3:0] s, input logic [1:0] cls);
        fire <= 1'b1;
        setup_code <= s;
        hold_code <= h;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk(sref_status, {h, s});
        chk(sref_margin_class, cls);
        apb(1'b0, SRM_STATUS_OFF, 32'h0, 4'h0);
        chk(rd, {24'h0, h, s});
    endtask

    task automatic lat_case(input logic [5:0] dec, input logic cx, input logic [3:0] m,
                            input logic [3:0] l, input logic [11:0] dsp,
                            input logic [11:0] lnk, input logic sup);
        apb(1'b1, SRM_LAT_CTRL_OFF, {16'h0, l, m, 1'b0, cx, dec}, 4'hf);
        repeat (2) @(posedge pclk);
        #1;
        chk(latency_supported, sup);
        chk(latency_dsp, dsp);
        chk(latency_link, lnk);
        chk(latency_total, 12'(dsp + lnk));
        apb(1'b0, SRM_LAT_TOTAL_OFF, 32'h0, 4'h0);
        chk(rd, {sup, 19'h0, 12'(dsp + lnk)});
        apb(1'b0, SRM_LAT_PART_OFF, 32'h0, 4'h0);
        chk(rd, {4'h0, lnk, 4'h0, dsp});
    endtask

    task automatic t_reset;
        @(posedge pclk);
        #1;
        chk(latency_total, 12'h02d);
        chk(latency_dsp, 12'h01f);
        chk(latency_link, 12'h00e);
        chk(latency_supported, 1'b1);
        chk(sref_status, 8'h00);
        apb(1'b0, SRM_LAT_CTRL_OFF, 32'h0, 4'h0);
        chk(rd, 32'h0000_1100);
    endtask

    task automatic t_capture;
        cap_case(4'h0, 4'h3, SRM_CLS_SETUP);
        cap_case(4'h5, 4'h8, SRM_CLS_OK);
        cap_case(4'h8, 4'hc, SRM_CLS_OK);
        cap_case(4'h8, 4'h0, SRM_CLS_OK);
        cap_case(4'hc, 4'h0, SRM_CLS_HOLD);
        cap_case(4'h0, 4'h0, SRM_CLS_EITHER);
        chk(sref_captured, 1'b1);
        apb(1'b1, SRM_MON_OFF, 32'h1, 4'h0);
        #1;
        chk(sref_captured, 1'b1);
        apb(1'b1, SRM_MON_OFF, 32'h1, 4'h1);
        @(posedge pclk);
        #1;
        chk(sref_captured, 1'b0);
    endtask

    // Writes to the status word must be accepted yet leave the captured codes alone.
    task automatic t_access;
        apb(1'b1, SRM_STATUS_OFF, 32'hff, 4'hf);
        chk(er, 1'b0);
        apb(1'b0, SRM_STATUS_OFF, 32'h0, 4'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h200, 32'h0, 4'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask

    task automatic t_latency;
        lat_case(6'h00, 1'b0, 4'h2, 4'h8, 12'h01f, 12'h02c, 1'b1);
        lat_case(6'h00, 1'b0, 4'h1, 4'h8, 12'h01f, 12'h052, 1'b1);
        lat_case(6'h02, 1'b1, 4'h1, 4'h1, 12'h05a, 12'h01b, 1'b1);
        lat_case(6'h03, 1'b1, 4'h1, 4'h1, 12'h066, 12'h027, 1'b1);
        lat_case(6'h04, 1'b1, 4'h2, 4'h4, 12'h0a2, 12'h058, 1'b1);
        lat_case(6'h04, 1'b0, 4'h1, 4'h1, 12'h124, 12'h032, 1'b1);
        lat_case(6'h04, 1'b1, 4'h1, 4'h1, 12'h0a2, 12'h032, 1'b1);
        lat_case(6'h05, 1'b0, 4'h1, 4'h1, 12'h17c, 12'h03e, 1'b1);
        lat_case(6'h05, 1'b1, 4'h1, 4'h1, 12'h000, 12'h000, 1'b0);
        lat_case(6'h0f, 1'b1, 4'h1, 4'h1, 12'h1f4, 12'h0b0, 1'b1);
        lat_case(6'h10, 1'b0, 4'h1, 4'h1, 12'h000, 12'h000, 1'b0);
        lat_case(6'h01, 1'b0, 4'h4, 4'h1, 12'h000, 12'h000, 1'b0);
        lat_case(6'h00, 1'b0, 4'h2, 4'h8, 12'h01f, 12'h02c, 1'b1);
    endtask

    task report_and_stop;
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole run needs well under two thousand cycles.
    initial begin
        #400000;
        n_errors++;
        report_and_stop;
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, fire} = 4'h0;
        {paddr, pwdata, pstrb, setup_code, hold_code} = 56'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_capture;
        t_access;
        t_latency;
        report_and_stop;
    end
endmodule
